// ---- shared/lsds_map.svh ----
`ifndef LSDS_MAP_SVH
`define LSDS_MAP_SVH

// ****************************************************************
// Descriptor field positions
// ****************************************************************
`define LSDS_BASE_HI 31
`define LSDS_BASE_LO 0
`define LSDS_LIM_HI 51
`define LSDS_LIM_LO 32
`define LSDS_TYPE_HI 55
`define LSDS_TYPE_LO 52
`define LSDS_TYPE_CODE_BIT 55
`define LSDS_SPARE_BIT 60
`define LSDS_RSVD_BIT 61
`define LSDS_SIZE_BIT 62
`define LSDS_GRAN_BIT 63

// ****************************************************************
// Segment slots and constants
// ****************************************************************
`define LSDS_SEG_CODE 3'h0
`define LSDS_SEG_STACK 3'h1
`define LSDS_GRAN_SHIFT 12
`define LSDS_EA16_MASK 32'h0000ffff
`define LSDS_DESC_RESET 64'h0000000000000000
`define LSDS_PRIV_RESET 2'h0
`define LSDS_IGN_MASK 64'hcfffffffffffffff

`endif

// ---- shared/lsds_pkg.sv ----
package lsds_pkg;
    typedef logic [63:0] lsds_desc_t;
    typedef logic [2:0] lsds_sel_t;
    typedef logic [1:0] lsds_priv_t;
endpackage

// ---- shared/lsds_if.sv ----
`timescale 1ns/1ps
interface lsds_if;
    logic wr_en;
    lsds_pkg::lsds_sel_t wr_sel;
    lsds_pkg::lsds_desc_t wr_data;
    lsds_pkg::lsds_sel_t rd_sel_a;
    lsds_pkg::lsds_desc_t rd_data_a;
    lsds_pkg::lsds_sel_t rd_sel_b;
    lsds_pkg::lsds_desc_t rd_data_b;
    lsds_pkg::lsds_desc_t code_desc;

    modport core (
        output wr_en, wr_sel, wr_data, rd_sel_a, rd_sel_b,
        input rd_data_a, rd_data_b, code_desc
    );
    modport mem (
        input wr_en, wr_sel, wr_data, rd_sel_a, rd_sel_b,
        output rd_data_a, rd_data_b, code_desc
    );
endinterface

// ---- rtl/lsds_desc_file.sv ----
`timescale 1ns/1ps
`include "lsds_map.svh"

module lsds_desc_file #(
    parameter int NUM_SEG = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Core side
    lsds_if.mem port
);
    lsds_pkg::lsds_desc_t store [NUM_SEG];
    logic wr_hit;
    logic a_ok;
    logic b_ok;

    assign wr_hit = port.wr_en && (int'(port.wr_sel) < NUM_SEG);
    assign a_ok = int'(port.rd_sel_a) < NUM_SEG;
    assign b_ok = int'(port.rd_sel_b) < NUM_SEG;

    // ****************************************************************
    // Storage, written as given with no field checks
    // ****************************************************************
    always_ff @(posedge clock) begin
        for (int i = 0; i < NUM_SEG; i++) begin
            if (rst) begin
                store[i] <= `LSDS_DESC_RESET;
            end else if (wr_hit && (int'(port.wr_sel) == i)) begin
                store[i] <= port.wr_data;
            end
        end
    end

    // Read data are registered; a read in the write cycle sees the old value
    always_ff @(posedge clock) begin
        if (rst) begin
            port.rd_data_a <= `LSDS_DESC_RESET;
            port.rd_data_b <= `LSDS_DESC_RESET;
            port.code_desc <= `LSDS_DESC_RESET;
        end else begin
            port.rd_data_a <= a_ok ? store[port.rd_sel_a] : `LSDS_DESC_RESET;
            port.rd_data_b <= b_ok ? store[port.rd_sel_b] : `LSDS_DESC_RESET;
            port.code_desc <= store[`LSDS_SEG_CODE];
        end
    end
endmodule // lsds_desc_file

// ---- rtl/lsds_top.sv ----
`timescale 1ns/1ps
`include "lsds_map.svh"

// Behaviour
// - Spare bit unused by legacy; optional keep
// - Reserved bit unused by legacy execution
// - Sixteen-byte ops: both ignored bits kept
// - Size bit clear truncates addresses to 16
// - Code size bit selects operand size
// - Granularity shifts limit left twelve bits
// - Instruction set switch keeps descriptors, privilege
// - Virtual mode data-typed code: no execute fault
// - Native writes stored without field checks
// - Base bits 31:0, limit bits 51:32
module lsds_top #(
    parameter int NUM_SEG = 6,
    parameter bit HAS_SIXTEEN_BYTE_OPS = 1'b1,
    parameter bit KEEP_IGNORED_BITS = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Native descriptor write
    input wire logic nat_wr_en,
    input wire lsds_pkg::lsds_sel_t nat_wr_sel,
    input wire lsds_pkg::lsds_desc_t nat_wr_data,
    // Native descriptor read
    input wire logic nat_rd_en,
    input wire lsds_pkg::lsds_sel_t nat_rd_sel,
    output logic nat_rd_valid,
    output lsds_pkg::lsds_desc_t nat_rd_data,
    // Privilege and mode
    input wire logic priv_wr_en,
    input wire lsds_pkg::lsds_priv_t priv_wr_data,
    input wire logic virtual_8086_flag,
    output lsds_pkg::lsds_priv_t current_privilege_level,
    output logic default_op32,
    // Legacy segment access
    input wire logic acc_valid,
    input wire logic acc_fetch,
    input wire lsds_pkg::lsds_sel_t acc_sel,
    input wire logic [31:0] acc_offset,
    output logic xlat_valid,
    output logic [31:0] xlat_addr,
    output logic xlat_addr32,
    output logic xlat_limit_fault,
    output logic xlat_exec_fault
);
    lsds_if dif ();

    lsds_desc_file #(
        .NUM_SEG(NUM_SEG)
    ) u_store (
        .clock(clock),
        .rst(rst),
        .port(dif.mem)
    );

    // ****************************************************************
    // Native access
    // ****************************************************************
    localparam bit KEEP_IGN = HAS_SIXTEEN_BYTE_OPS || KEEP_IGNORED_BITS;
    logic rd_pend;

    assign dif.wr_en = nat_wr_en;
    assign dif.wr_sel = nat_wr_sel;
    // Ignored bits are dropped only where the option allows it
    assign dif.wr_data = KEEP_IGN ? nat_wr_data : (nat_wr_data & `LSDS_IGN_MASK);
    assign dif.rd_sel_a = nat_rd_sel;
    assign nat_rd_valid = rd_pend;
    assign nat_rd_data = dif.rd_data_a;

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= nat_rd_en;
        end
    end

    // Privilege changes only by an explicit write, never by an ISA switch
    always_ff @(posedge clock) begin
        if (rst) begin
            current_privilege_level <= `LSDS_PRIV_RESET;
        end else if (priv_wr_en) begin
            current_privilege_level <= priv_wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            default_op32 <= 1'b0;
        end else begin
            default_op32 <= dif.code_desc[`LSDS_SIZE_BIT];
        end
    end

    // ****************************************************************
    // Legacy translation pipeline
    // ****************************************************************
    logic s1_valid;
    logic s1_fetch;
    logic s1_v86;
    logic [31:0] s1_offset;
    logic [31:0] s_base;
    logic [19:0] s_lim;
    logic [31:0] s_lim_scaled;
    logic s_size32;
    logic [31:0] s_ea;
    logic s_lim_fault;
    logic s_exec_fault;

    assign dif.rd_sel_b = acc_sel;
    // Spare and reserved bits are never looked at here
    assign s_base = dif.rd_data_b[`LSDS_BASE_HI:`LSDS_BASE_LO];
    assign s_lim = dif.rd_data_b[`LSDS_LIM_HI:`LSDS_LIM_LO];
    assign s_lim_scaled = dif.rd_data_b[`LSDS_GRAN_BIT] ? {s_lim[19:0], 12'h000} : {12'h000, s_lim};
    assign s_size32 = dif.rd_data_b[`LSDS_SIZE_BIT];
    assign s_ea = s_size32 ? s1_offset : (s1_offset & `LSDS_EA16_MASK);
    assign s_lim_fault = s_ea > s_lim_scaled;
    assign s_exec_fault = s1_fetch && !s1_v86 && !dif.rd_data_b[`LSDS_TYPE_CODE_BIT];

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_valid <= 1'b0;
            s1_fetch <= 1'b0;
            s1_v86 <= 1'b0;
            s1_offset <= 32'h00000000;
        end else begin
            s1_valid <= acc_valid;
            s1_fetch <= acc_fetch;
            s1_v86 <= virtual_8086_flag;
            s1_offset <= acc_offset;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            xlat_valid <= 1'b0;
            xlat_addr <= 32'h00000000;
            xlat_addr32 <= 1'b0;
            xlat_limit_fault <= 1'b0;
            xlat_exec_fault <= 1'b0;
        end else begin
            xlat_valid <= s1_valid;
            xlat_addr <= 32'(s_base + s_ea);
            xlat_addr32 <= s_size32;
            xlat_limit_fault <= s1_valid && s_lim_fault;
            xlat_exec_fault <= s1_valid && s_exec_fault;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [31:0] h_addr;
    logic [31:0] h_ea;
    logic h_fault;
    logic h_size32;

    always_ff @(posedge clock) begin
        if (rst) begin
            h_addr <= 32'h00000000;
            h_ea <= 32'h00000000;
            h_fault <= 1'b0;
            h_size32 <= 1'b0;
        end else begin
            h_addr <= 32'(s_base + s1_offset);
            h_ea <= s1_offset;
            // Limit scaled by a plain shift, apart from the datapath
            h_fault <= s1_offset > (dif.rd_data_b[`LSDS_GRAN_BIT] ?
                ({12'h000, s_lim} << `LSDS_GRAN_SHIFT) : {12'h000, s_lim});
            h_size32 <= s_size32;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_write;
        nat_wr_en && (int'(nat_wr_sel) < NUM_SEG);
    endsequence

    sequence s_read_back;
        nat_rd_en && !nat_wr_en && (nat_rd_sel == $past(nat_wr_sel));
    endsequence

    chk_read_timing: assert property (nat_rd_en |=> nat_rd_valid)
        else $error("read answer not one cycle after request");
    chk_read_pulse: assert property (!nat_rd_en |=> !nat_rd_valid)
        else $error("read answer without a request");
    chk_write_readback: assert property (s_write ##1 s_read_back |=>
        (nat_rd_data & `LSDS_IGN_MASK) == ($past(nat_wr_data, 2) & `LSDS_IGN_MASK))
        else $error("native read differs from last write");
    chk_ignored_bits: assert property (s_write ##1 s_read_back |=> KEEP_IGN ?
        (nat_rd_data[`LSDS_RSVD_BIT:`LSDS_SPARE_BIT] == $past(nat_wr_data[`LSDS_RSVD_BIT:`LSDS_SPARE_BIT], 2)) :
        (nat_rd_data[`LSDS_RSVD_BIT:`LSDS_SPARE_BIT] == 2'h0))
        else $error("ignored descriptor bits handled wrongly");
    chk_xlat_timing: assert property (acc_valid |-> ##2 xlat_valid)
        else $error("translation not two cycles after access");
    chk_addr_full: assert property (xlat_valid && xlat_addr32 |-> xlat_addr == h_addr)
        else $error("32-bit address not base plus offset");
    chk_addr_trunc: assert property (xlat_valid && !xlat_addr32 && (h_ea[31:16] == 16'h0000)
        |-> xlat_addr == h_addr)
        else $error("16-bit address wrong");
    chk_limit_scale: assert property (xlat_valid && h_size32 |-> xlat_limit_fault == h_fault)
        else $error("limit fault disagrees with scaled limit");
    chk_op_size: assert property (##1 1'b1 |-> default_op32 == $past(dif.code_desc[`LSDS_SIZE_BIT]))
        else $error("operand size not from code descriptor");
    chk_priv_hold: assert property (!priv_wr_en |=> $stable(current_privilege_level))
        else $error("privilege changed without a write");
    chk_v86_exec: assert property (s1_valid && s1_v86 |=> !xlat_exec_fault)
        else $error("execute fault raised in virtual mode");
endmodule // lsds_top

// ---- verif/lsds_top_tb_top.sv ----
`timescale 1ns/1ps
module lsds_top_tb_top;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clock, rst, nat_wr_en, nat_rd_en, priv_wr_en, virtual_8086_flag, acc_valid, acc_fetch;
    lsds_pkg::lsds_sel_t nat_wr_sel, nat_rd_sel, acc_sel;
    lsds_pkg::lsds_desc_t nat_wr_data, nat_rd_data, rd_val;
    lsds_pkg::lsds_priv_t priv_wr_data, current_privilege_level;
    logic [31:0] acc_offset, xlat_addr;
    logic nat_rd_valid, default_op32, xlat_valid, xlat_addr32, xlat_limit_fault, xlat_exec_fault;
    int n_mismatch, compares;

    lsds_top i_lsds_top (
        .clock(clock), .rst(rst),
        .nat_wr_en(nat_wr_en), .nat_wr_sel(nat_wr_sel), .nat_wr_data(nat_wr_data),
        .nat_rd_en(nat_rd_en), .nat_rd_sel(nat_rd_sel), .nat_rd_valid(nat_rd_valid), .nat_rd_data(nat_rd_data),
        .priv_wr_en(priv_wr_en), .priv_wr_data(priv_wr_data), .virtual_8086_flag(virtual_8086_flag),
        .current_privilege_level(current_privilege_level), .default_op32(default_op32),
        .acc_valid(acc_valid), .acc_fetch(acc_fetch), .acc_sel(acc_sel), .acc_offset(acc_offset),
        .xlat_valid(xlat_valid), .xlat_addr(xlat_addr), .xlat_addr32(xlat_addr32),
        .xlat_limit_fault(xlat_limit_fault), .xlat_exec_fault(xlat_exec_fault)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input lsds_pkg::lsds_sel_t s, input lsds_pkg::lsds_desc_t d);
        nat_wr_en = 1'b1;
        nat_wr_sel = s;
        nat_wr_data = d;
        @(negedge clock);
        nat_wr_en = 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input lsds_pkg::lsds_sel_t s, output lsds_pkg::lsds_desc_t d);
        nat_rd_en = 1'b1;
        nat_rd_sel = s;
        @(negedge clock);
        nat_rd_en = 1'b0;
        check("nat_rd_valid", {63'h0, nat_rd_valid}, 64'h1);
        d = nat_rd_data;
        @(negedge clock);
    endtask

    // Expected result is {addr, addr32, limit fault, exec fault}
    task automatic acc(input lsds_pkg::lsds_sel_t s, input logic f, input logic [31:0] off, input logic [34:0] e);
        int n;
        acc_valid = 1'b1;
        acc_fetch = f;
        acc_sel = s;
        acc_offset = off;
        @(negedge clock);
        acc_valid = 1'b0;
        for (n = 0; n < 4 && xlat_valid !== 1'b1; n++) @(negedge clock);
        if (xlat_valid !== 1'b1) begin
            n_mismatch++;
            $display("BAD xlat_valid expected 1 seen 0");
            print_verdict();
        end else begin
            check("xlat_latency", 64'(n), 64'h1);
            check("xlat_result", {29'h0, xlat_addr, xlat_addr32, xlat_limit_fault, xlat_exec_fault}, {29'h0, e});
            @(negedge clock);
        end
    endtask

    task automatic priv(input lsds_pkg::lsds_priv_t p);
        priv_wr_en = 1'b1;
        priv_wr_data = p;
        @(negedge clock);
        priv_wr_en = 1'b0;
        check("cpl_write", {62'h0, current_privilege_level}, {62'h0, p});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        n_mismatch = 0;
        compares = 0;
        rst = 1'b1;
        {nat_wr_en, nat_rd_en, priv_wr_en, virtual_8086_flag, acc_valid, acc_fetch} = 6'h00;
        {nat_wr_sel, nat_rd_sel, acc_sel} = 9'h000;
        nat_wr_data = 64'h0;
        priv_wr_data = 2'h0;
        acc_offset = 32'h0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("cpl_reset", {62'h0, current_privilege_level}, 64'h0);
        rd(3'h0, rd_val);
        check("desc_reset", rd_val, 64'h0);
        // Code slot with both ignored bits set and a 32-bit size
        wr(3'h0, 64'h7b90_ffff_0000_1000);
        rd(3'h0, rd_val);
        check("desc_code", rd_val, 64'h7b90_ffff_0000_1000);
        check("default_op32", {63'h0, default_op32}, 64'h1);
        acc(3'h0, 1'b1, 32'h0001_0000, {32'h0001_1000, 1'b1, 1'b1, 1'b0});
        acc(3'h0, 1'b0, 32'h0000_ffff, {32'h0001_0fff, 1'b1, 1'b0, 1'b0});
        // Stack slot, 16-bit, data typed
        wr(3'h1, 64'h0b20_ffff_0002_0000);
        acc(3'h1, 1'b0, 32'h1234_ffff, {32'h0002_ffff, 1'b0, 1'b0, 1'b0});
        acc(3'h1, 1'b1, 32'h0000_0010, {32'h0002_0010, 1'b0, 1'b0, 1'b1});
        virtual_8086_flag = 1'b1;
        acc(3'h1, 1'b1, 32'h0000_0010, {32'h0002_0010, 1'b0, 1'b0, 1'b0});
        virtual_8086_flag = 1'b0;
        // Page granular limit of one
        wr(3'h2, 64'h8b20_0001_0000_0000);
        acc(3'h2, 1'b0, 32'h0000_1000, {32'h0000_1000, 1'b0, 1'b0, 1'b0});
        acc(3'h2, 1'b0, 32'h0000_1001, {32'h0000_1001, 1'b0, 1'b1, 1'b0});
        // Size bit clear on the code slot gives 16-bit operands
        wr(3'h0, 64'h3b90_ffff_0000_1000);
        @(negedge clock);
        check("default_op32", {63'h0, default_op32}, 64'h0);
        // Slot outside the file is not stored
        wr(3'h6, 64'hffff_ffff_ffff_ffff);
        rd(3'h6, rd_val);
        check("desc_slot6", rd_val, 64'h0);
        // Read and write to one slot in the same cycle return the old word
        nat_wr_en = 1'b1;
        nat_wr_sel = 3'h2;
        nat_wr_data = 64'hc5a5_1234_89ab_cdef;
        rd(3'h2, rd_val);
        check("desc_collide", rd_val, 64'h8b20_0001_0000_0000);
        nat_wr_en = 1'b0;
        @(negedge clock);
        rd(3'h2, rd_val);
        check("desc_unchecked", rd_val, 64'hc5a5_1234_89ab_cdef);
        // Write then read the same slot in the next cycle
        nat_wr_en = 1'b1;
        nat_wr_sel = 3'h3;
        nat_wr_data = 64'hf930_ffff_0003_0000;
        @(negedge clock);
        nat_wr_en = 1'b0;
        rd(3'h3, rd_val);
        check("desc_back2back", rd_val, 64'hf930_ffff_0003_0000);
        // Null data slot with the present bit clear
        wr(3'h4, 64'h0130_0000_0000_0000);
        rd(3'h4, rd_val);
        check("desc_null", rd_val, 64'h0130_0000_0000_0000);
        // Mode change leaves descriptors and privilege alone
        priv(2'h3);
        virtual_8086_flag = 1'b1;
        repeat (3) @(negedge clock);
        virtual_8086_flag = 1'b0;
        @(negedge clock);
        rd(3'h0, rd_val);
        check("desc_kept", rd_val, 64'h3b90_ffff_0000_1000);
        check("cpl_kept", {62'h0, current_privilege_level}, 64'h3);
        // Virtual mode code slot: privilege three, 16-bit, data typed, base selector times sixteen
        wr(3'h0, 64'h0f30_ffff_0001_0000);
        virtual_8086_flag = 1'b1;
        acc(3'h0, 1'b1, 32'h0000_ffff, {32'h0001_ffff, 1'b0, 1'b0, 1'b0});
        virtual_8086_flag = 1'b0;
        // Real mode stack slot at privilege zero
        priv(2'h0);
        wr(3'h1, 64'h0930_ffff_0000_2000);
        acc(3'h1, 1'b0, 32'h0001_ffff, {32'h0001_1fff, 1'b0, 1'b0, 1'b0});
        // Protected mode code slot at the current privilege, page granular, 32-bit
        wr(3'h0, 64'hc9bf_ffff_0000_0000);
        acc(3'h0, 1'b1, 32'h8000_0000, {32'h8000_0000, 1'b1, 1'b0, 1'b0});
        check("default_op32", {63'h0, default_op32}, 64'h1);
        print_verdict();
    end
endmodule // lsds_top_tb_top
